// ---- rtl/fcg_defs.svh ----
`ifndef FCG_DEFS_SVH
`define FCG_DEFS_SVH

// Command codes of the write-type commands, write enable and disable, and the reads
`define FCG_OP_WREN        8'h06
`define FCG_OP_WRDI        8'h04
`define FCG_OP_SSE_A       8'hd7
`define FCG_OP_SSE_B       8'h20
`define FCG_OP_SE          8'hd8
`define FCG_OP_CE          8'hc7
`define FCG_OP_PP          8'h02
`define FCG_OP_WRSR        8'h01
`define FCG_OP_READ        8'h03
`define FCG_OP_FREAD       8'h0b

// Field positions of the serial bit counter and width of the bus cycle counter
`define FCG_BIT_LSB        0
`define FCG_BIT_MSB        2
`define FCG_CYC_W          16

// Bus cycles that make up each command shape
`define FCG_CYC_OPCODE     16'h0001
`define FCG_CYC_ADDR_END   16'h0004
`define FCG_CYC_WRSR_MAX   16'h0002

// Power-on waits in their own units and in sys_clk cycles at 40 MHz
`define FCG_CLK_KHZ        40000
`define FCG_READ_WAIT_US   100
`define FCG_WRITE_WAIT_MS  10
`define FCG_READ_WAIT_CYC  ((`FCG_READ_WAIT_US * `FCG_CLK_KHZ) / 1000)
`define FCG_WRITE_WAIT_CYC (`FCG_WRITE_WAIT_MS * `FCG_CLK_KHZ)

// Reset values
`define FCG_RST_WEN        1'b0

`endif

// ---- rtl/fcg_pkg.sv ----
package fcg_pkg;

    typedef enum logic [1:0]
    {
        FCG_ST_IDLE = 2'b00,
        FCG_ST_CMD  = 2'b01,
        FCG_ST_BODY = 2'b10
    } fcg_state_e;

    typedef enum logic [2:0]
    {
        FCG_OP_NONE  = 3'b000,
        FCG_OP_ERASE = 3'b001,
        FCG_OP_PROG  = 3'b010,
        FCG_OP_SRWR  = 3'b011,
        FCG_OP_RD    = 3'b100
    } fcg_op_e;

endpackage

// ---- rtl/fcg_por_timer.sv ----
`timescale 1ns/1ps
`include "fcg_defs.svh"

// Counts from reset release up to the longer of two power-on waits
module fcg_por_timer
#(
    parameter int READ_CYC  = `FCG_READ_WAIT_CYC,
    parameter int WRITE_CYC = `FCG_WRITE_WAIT_CYC
)
(
    input  wire logic sys_clk,     // System clock
    input  wire logic rst_n,       // Synchronous reset, active low
    output logic      read_ok,     // Read startup wait elapsed
    output logic      write_ok     // Write startup wait elapsed
);
    localparam int CW = $clog2(WRITE_CYC + 1);

    if (READ_CYC < 1 || WRITE_CYC < READ_CYC)
    begin : g_bad_wait
        $error("fcg_por_timer: wait counts must satisfy 1 <= read <= write");
    end

    typedef struct packed
    {
        logic [CW-1:0] cnt;
        logic          rd;
        logic          wr;
    } fcg_por_s;

    fcg_por_s st_r;
    fcg_por_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (!st_r.wr)
            st_nxt.cnt = st_r.cnt + CW'(1);
        if (st_r.cnt >= CW'(READ_CYC))
            st_nxt.rd = 1'b1;
        if (st_r.cnt >= CW'(WRITE_CYC))
            st_nxt.wr = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign read_ok  = st_r.rd;
    assign write_ok = st_r.wr;
endmodule // fcg_por_timer

// ---- rtl/fcg_guard.sv ----
`timescale 1ns/1ps
`include "fcg_defs.svh"

module fcg_guard
    import fcg_pkg::*;
#(
    parameter int READ_WAIT_CYC  = `FCG_READ_WAIT_CYC,
    parameter int WRITE_WAIT_CYC = `FCG_WRITE_WAIT_CYC
)
(
    input  wire logic       sys_clk,       // System clock, 40 MHz
    input  wire logic       rst_n,         // Synchronous reset, active low (power-on reset)
    input  wire logic       cs_n,          // Chip select, active low
    input  wire logic       sck,           // Serial clock, sampled
    input  wire logic       si,            // Serial data in
    input  wire logic       busy,          // Internal write in progress
    output logic            wen,           // Write enable latch
    output logic            erase_go,      // Accepted erase pulse
    output logic            prog_go,       // Accepted page program pulse
    output logic            srwr_go,       // Accepted status write pulse
    output logic            cmd_reject,    // Write-type command dropped pulse
    output logic            read_ready,    // Read startup wait elapsed
    output logic            write_ready,   // Write startup wait elapsed
    output logic [7:0]      opcode         // Last opcode received
);
    import fcg_pkg::*;

    // A write wait shorter than the read wait would let write_ready lead read_ready
    if (READ_WAIT_CYC < 1 || WRITE_WAIT_CYC < READ_WAIT_CYC)
    begin : g_bad_wait
        $error("fcg_guard: bad startup wait counts");
    end

    // The cycle count must reach past the address phase to tell a page load apart
    if (`FCG_CYC_W < 3)
    begin : g_bad_cyc_w
        $error("fcg_guard: cycle counter too narrow");
    end

    typedef struct packed
    {
        fcg_state_e                st;
        fcg_op_e                   op;
        logic [2:0]                bits;
        logic [`FCG_CYC_W-1:0]     cycles;
        logic [7:0]                sh;
        logic [7:0]                opc;
        logic                      sck_d;
        logic                      cs_d;
        logic                      wen;
        logic                      erase_go;
        logic                      prog_go;
        logic                      srwr_go;
        logic                      rej;
        logic                      rd_ok;
        logic                      wr_ok;
    } fcg_guard_s;

    fcg_guard_s s_r;
    fcg_guard_s s_nxt;
    logic       rd_ok_w;
    logic       wr_ok_w;

    // Classifies a received opcode into its guard class
    function automatic fcg_op_e classify(input logic [7:0] c);
        case (c)
            `FCG_OP_SSE_A, `FCG_OP_SSE_B, `FCG_OP_SE, `FCG_OP_CE: classify = FCG_OP_ERASE;
            `FCG_OP_PP:                                            classify = FCG_OP_PROG;
            `FCG_OP_WRSR:                                          classify = FCG_OP_SRWR;
            `FCG_OP_READ, `FCG_OP_FREAD:                           classify = FCG_OP_RD;
            default:                                               classify = FCG_OP_NONE;
        endcase
    endfunction

    // True for the guarded write classes
    function automatic logic is_write(input fcg_op_e o);
        is_write = (o == FCG_OP_ERASE) || (o == FCG_OP_PROG) || (o == FCG_OP_SRWR);
    endfunction

    fcg_por_timer
    #(
        .READ_CYC  (READ_WAIT_CYC),
        .WRITE_CYC (WRITE_WAIT_CYC)
    )
    fcg_por_timer_inst
    (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .read_ok  (rd_ok_w),
        .write_ok (wr_ok_w)
    );

    logic       sck_rise;
    logic       cs_rise;
    logic       cs_fall;
    logic [7:0] byte_w;
    logic       aligned;
    logic       shape_ok;

    always_comb
    begin
        // Clock edges outside chip select are ignored, so a free-running host clock is harmless
        sck_rise = sck && !s_r.sck_d && !cs_n;
        cs_rise  = cs_n && !s_r.cs_d;
        cs_fall  = !cs_n && s_r.cs_d;
        byte_w   = {s_r.sh[6:0], si};
        aligned  = (s_r.bits == 3'd0);
        shape_ok = 1'b0;

        s_nxt          = s_r;
        s_nxt.sck_d    = sck;
        s_nxt.cs_d     = cs_n;
        s_nxt.erase_go = 1'b0;
        s_nxt.prog_go  = 1'b0;
        s_nxt.srwr_go  = 1'b0;
        s_nxt.rej      = 1'b0;
        s_nxt.rd_ok    = rd_ok_w;
        s_nxt.wr_ok    = wr_ok_w;

        // A new frame drops whatever bit count a cut frame left behind
        if (cs_fall)
        begin
            s_nxt.st     = FCG_ST_CMD;
            s_nxt.bits   = 3'd0;
            s_nxt.cycles = '0;
            s_nxt.op     = FCG_OP_NONE;
        end
        // The outcome is decided on the closing chip-select edge, where the operation would start
        else if (cs_rise)
        begin
            s_nxt.st = FCG_ST_IDLE;
            if (s_r.st == FCG_ST_BODY)
            begin
                // Shape is judged on whole bus cycles; a trailing part byte fails alignment instead
                unique case (s_r.op)
                    FCG_OP_ERASE:
                        shape_ok = (s_r.opc == `FCG_OP_CE) ? (s_r.cycles == `FCG_CYC_OPCODE)
                                                           : (s_r.cycles == `FCG_CYC_ADDR_END);
                    FCG_OP_PROG:
                        shape_ok = (s_r.cycles > `FCG_CYC_ADDR_END);
                    FCG_OP_SRWR:
                        shape_ok = (s_r.cycles > `FCG_CYC_OPCODE) &&
                                   (s_r.cycles < `FCG_CYC_OPCODE + `FCG_CYC_WRSR_MAX);
                    FCG_OP_RD, FCG_OP_NONE:
                        shape_ok = 1'b0;
                endcase
                if (is_write(s_r.op))
                begin
                    // Busy device and early supply both refuse writes as well
                    if (aligned && shape_ok && s_r.wen && s_r.wr_ok && !busy)
                    begin
                        s_nxt.erase_go = (s_r.op == FCG_OP_ERASE);
                        s_nxt.prog_go  = (s_r.op == FCG_OP_PROG);
                        s_nxt.srwr_go  = (s_r.op == FCG_OP_SRWR);
                        s_nxt.wen      = 1'b0;
                    end
                    else
                        s_nxt.rej = 1'b1;
                end
                // Write enable and disable count only as clean one-byte frames
                else if (aligned && s_r.cycles == `FCG_CYC_OPCODE && !busy)
                begin
                    if (s_r.opc == `FCG_OP_WREN)
                        s_nxt.wen = 1'b1;
                    else if (s_r.opc == `FCG_OP_WRDI)
                        s_nxt.wen = 1'b0;
                end
            end
        end
        else if (sck_rise && s_r.st != FCG_ST_IDLE)
        begin
            s_nxt.sh   = byte_w;
            s_nxt.bits = s_r.bits + 3'd1;
            if (s_r.bits == 3'd7)
            begin
                s_nxt.cycles = s_r.cycles + `FCG_CYC_W'(1);
                if (s_r.st == FCG_ST_CMD)
                begin
                    s_nxt.st  = FCG_ST_BODY;
                    // Kept after the frame so the last command stays visible
                    s_nxt.opc = byte_w;
                    s_nxt.op  = classify(byte_w);
                end
            end
            // Saturate so very long page loads cannot wrap the cycle count
            if (s_r.cycles == '1)
                s_nxt.cycles = s_r.cycles;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_r       <= '0;
            s_r.st    <= FCG_ST_IDLE;
            s_r.wen   <= `FCG_RST_WEN;
            // Chip select starts high so reset release never looks like a closing edge; a chip select already low then starts a frame
            s_r.cs_d  <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign wen         = s_r.wen;
    assign erase_go    = s_r.erase_go;
    assign prog_go     = s_r.prog_go;
    assign srwr_go     = s_r.srwr_go;
    assign cmd_reject  = s_r.rej;
    // Read readiness is reported only; the host keeps the read wait itself
    assign read_ready  = s_r.rd_ok;
    assign write_ready = s_r.wr_ok;
    assign opcode      = s_r.opc;
endmodule // fcg_guard

// ---- verif/fcg_guard_monitor.sv ----
`timescale 1ns/1ps
module fcg_guard_monitor
(
    input wire logic sys_clk,     // Clock
    input wire logic rst_n,       // Reset, active low
    input wire logic cs_n,        // Chip select
    input wire logic busy,        // Write in progress
    input wire logic wen,         // Write enable latch
    input wire logic erase_go,    // Erase accepted
    input wire logic prog_go,     // Program accepted
    input wire logic srwr_go,     // Status write accepted
    input wire logic cmd_reject,  // Command dropped
    input wire logic read_ready,  // Read wait over
    input wire logic write_ready  // Write wait over
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire go = erase_go | prog_go | srwr_go;

    one_outcome_a: assert property ($onehot0({erase_go, prog_go, srwr_go, cmd_reject}))
        else $error("two outcomes at once");
    answer_slot_a: assert property ((go | cmd_reject) |-> $past(cs_n) && !$past(cs_n, 2))
        else $error("outcome off the chip select rise");
    go_needs_wen_a: assert property (go |-> $past(wen))
        else $error("write accepted without write enable");
    wen_drop_a: assert property (go |-> !wen)
        else $error("write enable kept after a write");
    go_ready_a: assert property (go |-> write_ready && !$past(busy))
        else $error("write accepted too early or while busy");
    ready_order_a: assert property (write_ready |-> read_ready)
        else $error("write wait ended before read wait");
    ready_keep_a: assert property (read_ready |=> read_ready)
        else $error("read ready dropped");
    reset_idle_a: assert property ($rose(rst_n) |-> !wen && !go && !cmd_reject && !read_ready)
        else $error("not idle after reset");
    pulse_single_a: assert property (cmd_reject |=> !cmd_reject)
        else $error("reject longer than one cycle");

    cover property (erase_go);
    cover property (prog_go);
    cover property (srwr_go);
    cover property (cmd_reject);
endmodule // fcg_guard_monitor

bind fcg_guard fcg_guard_monitor fcg_guard_monitor_inst (.sys_clk, .rst_n, .cs_n, .busy, .wen, .erase_go,
    .prog_go, .srwr_go, .cmd_reject, .read_ready, .write_ready);

// ---- verif/fcg_host_model.sv ----
`timescale 1ns/1ps
module fcg_host_model
(
    input  wire logic sys_clk, // Clock
    output logic      cs_n,    // Chip select, active low
    output logic      sck,     // Serial clock, idle low
    output logic      si       // Serial data to the device
);
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // Sends n bits MSB first from bit 63; si flips at release so no stale bit looks valid
    task automatic xfer(input logic [63:0] d, input int n);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            sck <= 1'b0;
            si  <= d[63-i];
            @(posedge sys_clk);
            sck <= 1'b1;
        end
        @(posedge sys_clk);
        sck <= 1'b0;
        @(posedge sys_clk);
        cs_n <= 1'b1;
        si   <= ~si;
    endtask
endmodule // fcg_host_model

// ---- verif/test_flash_command_guard_power_on.sv ----
`timescale 1ns/1ps
module test_flash_command_guard_power_on;
    localparam int          RD_CYC = 4;
    localparam int          WR_CYC = 20;
    localparam logic [63:0] WREN_F = 64'h0600_0000_0000_0000;
    logic       sys_clk = 1'b0;
    logic       rst_n, busy, cs_n, sck, si;
    logic       wen, erase_go, prog_go, srwr_go, cmd_reject, read_ready, write_ready;
    logic [7:0] opcode;
    int         errors = 0;
    int         total_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    fcg_host_model fcg_host_model_inst (.sys_clk, .cs_n, .sck, .si);
    fcg_guard #(.READ_WAIT_CYC(RD_CYC), .WRITE_WAIT_CYC(WR_CYC)) fcg_guard_inst (.sys_clk, .rst_n, .cs_n,
        .sck, .si, .busy, .wen, .erase_go, .prog_go, .srwr_go, .cmd_reject, .read_ready, .write_ready, .opcode);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Outcome nibble is {erase, program, status write, reject}
    task automatic do_cmd(input logic [63:0] d, input int n, input logic [3:0] exp);
        fcg_host_model_inst.xfer(d, n);
        // The outcome pulse stands only in the cycle after the edge that sees chip select high
        @(posedge sys_clk);
        #1;
        check({erase_go, prog_go, srwr_go, cmd_reject}, exp);
        check(opcode, d[63:56]);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic t_power;
        check({wen, read_ready, write_ready}, 3'b000);
        repeat (RD_CYC + 4) @(posedge sys_clk);
        #1;
        check({read_ready, write_ready}, 2'b10);
        repeat (WR_CYC) @(posedge sys_clk);
        #1;
        check(write_ready, 1'b1);
        $display("test power done");
    endtask

    task automatic t_accept;
        logic [63:0] d [6] = '{64'hd712_3456_0000_0000, 64'h2000_1000_0000_0000, 64'hd803_0000_0000_0000,
                               64'hc700_0000_0000_0000, 64'h0200_0100_a55a_0000, 64'h011c_0000_0000_0000};
        int          n [6] = '{32, 32, 32, 8, 48, 16};
        logic [3:0]  e [6] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h4, 4'h2};
        for (int i = 0; i < 6; i++)
        begin
            do_cmd(WREN_F, 8, 4'h0);
            check(wen, 1'b1);
            do_cmd(d[i], n[i], e[i]);
            check(wen, 1'b0);
        end
        $display("test accept done");
    endtask

    // Bit counts off a byte boundary, partial page data, three-cycle status write
    task automatic t_reject;
        logic [63:0] d [4] = '{64'hd801_0000_0000_0000, 64'hc7f0_0000_0000_0000, 64'h0200_0000_ff00_0000,
                               64'h0100_0000_0000_0000};
        int          n [4] = '{31, 12, 43, 24};
        for (int i = 0; i < 4; i++)
        begin
            do_cmd(WREN_F, 8, 4'h0);
            do_cmd(d[i], n[i], 4'h1);
        end
        $display("test reject done");
    endtask

    task automatic t_refuse;
        do_cmd(64'h0400_0000_0000_0000, 8, 4'h0);
        check(wen, 1'b0);
        do_cmd(64'hc700_0000_0000_0000, 8, 4'h1);
        do_cmd(WREN_F, 8, 4'h0);
        do_cmd(64'h0312_3456_0000_0000, 40, 4'h0);
        check(wen, 1'b1);
        busy <= 1'b1;
        do_cmd(64'hc700_0000_0000_0000, 8, 4'h1);
        busy <= 1'b0;
        $display("test refuse done");
    endtask

    // Reset in mid-run clears write enable and restarts both startup waits
    task automatic t_reset;
        do_cmd(WREN_F, 8, 4'h0);
        check(wen, 1'b1);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check({wen, read_ready, write_ready}, 3'b000);
        repeat (WR_CYC + 4) @(posedge sys_clk);
        #1;
        check({wen, read_ready, write_ready}, 3'b011);
        $display("test reset done");
    endtask

    initial
    begin
        #500000;
        errors++;
        complete_run();
    end

    initial
    begin
        rst_n = 1'b0;
        busy  = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_power(); // Host holds off writes until the write wait is over
        t_accept();
        t_reject();
        t_refuse();
        t_reset();
        complete_run();
    end
endmodule // test_flash_command_guard_power_on
